// [spi_chan_params.svh]
`ifndef SPI_CHAN_PARAMS_SVH
`define SPI_CHAN_PARAMS_SVH
// ****************************************
// frame and buffer sizes
// ****************************************
`define DATA_W 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define LEN_8 4'h8
`define LEN_7 4'h7
// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_CNT 4'h0
`define RST_BIT 1'b0
// ****************************************
// timing: master clock at most operation clock / 6
// ****************************************
`define SCLK_MIN_DIV 6
`endif

// [spi_chan_pkg.sv]
`default_nettype none
package spi_chan_pkg;
	// channel_comm_config fields, static while the channel is armed
	typedef struct packed {
		logic duplex;                 // 1: transmit and receive, 0: receive only
		logic continuous;             // 1: buffer-empty irq (duplex only), 0: transfer-end irq
		logic data_phase_select;      // 1: received data half a clock earlier, transmitted data half a clock later
		logic clock_polarity_select;  // 1: serial clock used inverted
		logic lsb_first;
		logic len7;                   // 1: 7-bit frames, 0: 8-bit frames
	} cfg_t;
	typedef struct packed {
		logic armed;
		logic tx_buffer_full;
		logic overrun_flag;
	} status_t;
endpackage
`default_nettype wire

// [spi_slave_receive_channel.sv]
`timescale 1ns/100ps
`include "spi_chan_params.svh"
`default_nettype none

// ****************************************
// receive buffer
// ****************************************
module spi_chan_fifo #(
	parameter int WIDTH = `DATA_W,
	parameter int DEPTH = `FIFO_DEPTH,
	parameter int AW = `FIFO_AW
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty
	assign in_ready = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
	assign out_valid = wr_ptr_r != rd_ptr_r;
	assign out_data = mem[rd_ptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage has no reset, only pointers matter
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

// ****************************************
// channel top
// ****************************************
module spi_slave_receive_channel (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic slave_serial_clock_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	input wire spi_chan_pkg::cfg_t channel_comm_config,
	input wire logic channel_start_trigger,
	input wire logic channel_stop_trigger,
	input wire logic tx_write,
	input wire logic [7:0] tx_data,
	input wire logic rx_read,
	output logic rx_valid,
	output logic [7:0] serial_data_reg,
	input wire logic overrun_clear,
	output spi_chan_pkg::status_t status,
	output logic channel_transfer_irq
);
	import spi_chan_pkg::*;

	// ****************************************
	// functions
	// ****************************************
	// event once synchroniser stages two and three agree on a new value
	function automatic logic tgl_event(input logic s2, input logic s3, input logic seen);
		tgl_event = (s2 == s3) && (s3 != seen);
	endfunction

	function automatic logic [3:0] frame_len(input cfg_t c);
		frame_len = c.len7 ? `LEN_7 : `LEN_8;
	endfunction

	// ****************************************
	// operation clock: arm, stop, transmit hold
	// ****************************************
	logic enable_r;
	logic [7:0] tx_hold_r;
	logic tx_full_r;
	logic take_evt;

	// stop wins over a simultaneous start so a halt is never missed
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			enable_r <= `RST_BIT;
		end else if (channel_stop_trigger) begin
			enable_r <= 1'b0;
		end else if (channel_start_trigger) begin
			enable_r <= 1'b1;
		end
	end

	// a new write overwrites a word still waiting in the hold register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_hold_r <= `RST_BYTE;
		end else if (tx_write) begin
			tx_hold_r <= tx_data;
		end
	end

	// write sets, take by the link clears; set wins
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_full_r <= `RST_BIT;
		end else if (tx_write) begin
			tx_full_r <= 1'b1;
		end else if (take_evt || !enable_r) begin
			tx_full_r <= 1'b0;
		end
	end

	// ****************************************
	// link clock domain
	// ****************************************
	// the link logic is held in reset while not armed, so a stop ends any
	// frame mid-way and the master's clock is ignored until armed again
	logic link_rst_n;
	logic lclk;
	logic [3:0] rx_cnt_r;
	logic [7:0] rx_sh_r;
	logic [7:0] rx_word_r;
	logic done_tgl_r;
	logic [3:0] tx_cnt_r;
	logic [7:0] tx_sh_r;
	logic drv_r;
	logic take_tgl_r;
	logic [7:0] rx_next;

	assign link_rst_n = enable_r;
	// polarity inverts the clock, phase moves both edges by half a period;
	// config must only change while stopped, the mux would glitch otherwise
	assign lclk = slave_serial_clock_in ^ channel_comm_config.clock_polarity_select
		^ channel_comm_config.data_phase_select;
	assign rx_next = channel_comm_config.lsb_first ? {serial_data_in, rx_sh_r[7:1]}
		: {rx_sh_r[6:0], serial_data_in};

	// sample edge: shift in, hand the frame over on its last bit
	always_ff @(posedge lclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_cnt_r <= `RST_CNT;
			rx_sh_r <= `RST_BYTE;
			rx_word_r <= `RST_BYTE;
			done_tgl_r <= `RST_BIT;
		end else if (rx_cnt_r == frame_len(channel_comm_config) - 4'h1) begin
			rx_cnt_r <= `RST_CNT;
			rx_sh_r <= rx_next;
			done_tgl_r <= ~done_tgl_r;
			if (channel_comm_config.lsb_first && channel_comm_config.len7) begin
				rx_word_r <= {1'b0, rx_next[7:1]};
			end else if (channel_comm_config.len7) begin
				rx_word_r <= {1'b0, rx_next[6:0]};
			end else begin
				rx_word_r <= rx_next;
			end
		end else begin
			rx_cnt_r <= rx_cnt_r + 4'h1;
			rx_sh_r <= rx_next;
		end
	end

	// drive edge: in both phases the first bit of a frame is loaded on that frame's
	// own first drive edge; with phase 1 that edge follows the first sample edge
	always_ff @(negedge lclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_cnt_r <= `RST_CNT;
			tx_sh_r <= `RST_BYTE;
			drv_r <= `RST_BIT;
			take_tgl_r <= `RST_BIT;
		end else if (!channel_comm_config.duplex) begin
			drv_r <= `RST_BIT;
		end else if (tx_cnt_r == `RST_CNT) begin
			// hold register is stable: written before the master starts
			take_tgl_r <= ~take_tgl_r;
			tx_cnt_r <= frame_len(channel_comm_config) - 4'h1;
			drv_r <= channel_comm_config.lsb_first ? tx_hold_r[0]
				: (channel_comm_config.len7 ? tx_hold_r[6] : tx_hold_r[7]);
			tx_sh_r <= channel_comm_config.lsb_first ? {1'b0, tx_hold_r[7:1]}
				: (channel_comm_config.len7 ? {tx_hold_r[5:0], 2'b00} : {tx_hold_r[6:0], 1'b0});
		end else begin
			tx_cnt_r <= tx_cnt_r - 4'h1;
			drv_r <= channel_comm_config.lsb_first ? tx_sh_r[0] : tx_sh_r[7];
			tx_sh_r <= channel_comm_config.lsb_first ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
		end
	end

	assign serial_data_out = drv_r;

	// ****************************************
	// crossings back to the operation clock
	// ****************************************
	logic [2:0] done_s_r;
	logic [2:0] take_s_r;
	logic done_seen_r;
	logic take_seen_r;
	logic rx_evt;

	// stage one feeds stage two only; edges are judged on stages two and three
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			done_s_r <= 3'h0;
			take_s_r <= 3'h0;
			done_seen_r <= `RST_BIT;
			take_seen_r <= `RST_BIT;
		end else begin
			done_s_r <= {done_s_r[1:0], done_tgl_r};
			take_s_r <= {take_s_r[1:0], take_tgl_r};
			if (done_s_r[1] == done_s_r[2]) begin
				done_seen_r <= done_s_r[2];
			end
			if (take_s_r[1] == take_s_r[2]) begin
				take_seen_r <= take_s_r[2];
			end
		end
	end

	// the word register holds many operation clocks after its toggle,
	// the master clock limit guarantees that
	assign rx_evt = tgl_event(done_s_r[1], done_s_r[2], done_seen_r) && enable_r;
	assign take_evt = tgl_event(take_s_r[1], take_s_r[2], take_seen_r) && enable_r;

	// ****************************************
	// receive buffer, overrun, data register
	// ****************************************
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic overrun_r;
	logic rx_valid_r;
	logic [7:0] rx_data_r;

	spi_chan_fifo #(
		.WIDTH(`DATA_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_rx_fifo (
		.mclk(mclk),
		.resetn(resetn),
		.in_valid(rx_evt),
		.in_ready(fifo_in_ready),
		.in_data(rx_word_r),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// a full buffer drops the new frame and flags it; set beats clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			overrun_r <= `RST_BIT;
		end else if (rx_evt && !fifo_in_ready) begin
			overrun_r <= 1'b1;
		end else if (overrun_clear) begin
			overrun_r <= 1'b0;
		end
	end

	// output stage keeps the data register a flop; read pops it
	assign fifo_out_ready = !rx_valid_r || rx_read;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rx_valid_r <= `RST_BIT;
			rx_data_r <= `RST_BYTE;
		end else if (fifo_out_ready) begin
			rx_valid_r <= fifo_out_valid;
			if (fifo_out_valid) begin
				rx_data_r <= fifo_out_data;
			end
		end
	end

	assign rx_valid = rx_valid_r;
	assign serial_data_reg = rx_data_r;

	// ****************************************
	// interrupt request and status
	// ****************************************
	logic irq_r;
	status_t status_r;

	// receive-only always uses transfer end, whatever continuous says
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_r <= `RST_BIT;
		end else if (channel_comm_config.duplex && channel_comm_config.continuous) begin
			irq_r <= take_evt;
		end else begin
			irq_r <= rx_evt;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_r <= '0;
		end else begin
			status_r.armed <= enable_r;
			status_r.tx_buffer_full <= tx_full_r;
			status_r.overrun_flag <= overrun_r;
		end
	end

	assign channel_transfer_irq = irq_r;
	assign status = status_r;
endmodule
`default_nettype wire

// [spi_slave_receive_channel_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// port checker
// ********
module spi_chan_checker (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic slave_serial_clock_in,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire spi_chan_pkg::cfg_t channel_comm_config,
	input wire logic channel_start_trigger,
	input wire logic channel_stop_trigger,
	input wire logic tx_write,
	input wire logic [7:0] tx_data,
	input wire logic rx_read,
	input wire logic rx_valid,
	input wire logic [7:0] serial_data_reg,
	input wire logic overrun_clear,
	input wire spi_chan_pkg::status_t status,
	input wire logic channel_transfer_irq
);
	import spi_chan_pkg::*;
	// only the operation clock is visible at the ports
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// status trails the internal state by one cycle, hence the two-cycle figures
	a_start_arms: assert property (channel_start_trigger && !channel_stop_trigger |-> ##2 status.armed)
		else $error("start did not arm");
	a_stop_disarms: assert property (channel_stop_trigger |-> ##2 !status.armed)
		else $error("stop did not disarm");
	a_tx_hold_full: assert property (tx_write |-> ##2 status.tx_buffer_full)
		else $error("tx hold not marked full");
	a_irq_one_cycle: assert property (channel_transfer_irq |=> !channel_transfer_irq)
		else $error("irq wider than one cycle");
	a_rx_word_stands: assert property (rx_valid && !rx_read |=> rx_valid && $stable(serial_data_reg))
		else $error("unread frame lost");
	a_short_frame_top: assert property (channel_comm_config.len7 && rx_valid |-> !serial_data_reg[7])
		else $error("7-bit frame has bit 7 set");
	a_rx_only_quiet: assert property (!channel_comm_config.duplex |-> !serial_data_out)
		else $error("data out driven in receive only");
	a_overrun_sticky: assert property (status.overrun_flag && !overrun_clear
		&& !$past(overrun_clear) |=> status.overrun_flag)
		else $error("overrun dropped without clear");
endmodule
bind spi_slave_receive_channel spi_chan_checker i_spi_chan_checker (.*);
`default_nettype wire

// [spi_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// external master, clock runs only inside frames
// ********
module spi_master_model (
	output logic slave_serial_clock_in,
	output logic serial_data_in,
	input wire logic serial_data_out
);
	import spi_chan_pkg::*;
	initial begin
		slave_serial_clock_in = 1'b0;
		serial_data_in = 1'b0;
	end
	// idle level is the inverse of the polarity setting; only moved while unarmed
	task automatic park(logic pol);
		slave_serial_clock_in = ~pol;
	endtask
	// 150 ns period keeps within six operation clocks the slave never makes the clock
	task automatic xfer(cfg_t c, logic [7:0] d, int nb, output logic [7:0] r);
		int len;
		len = c.len7 ? 7 : 8;
		r = 8'h00;
		if (nb > len) nb = len;
		#3;
		// phase 0 opens each bit with a drive edge; phase 1 samples first, bit already out
		for (int i = 0; i < nb; i++) begin
			if (!c.data_phase_select) slave_serial_clock_in = ~slave_serial_clock_in;
			serial_data_in = c.lsb_first ? d[i] : d[len-1-i];
			#75;
			r[c.lsb_first ? i : len-1-i] = serial_data_out;
			slave_serial_clock_in = ~slave_serial_clock_in;
			#75;
			if (c.data_phase_select) slave_serial_clock_in = ~slave_serial_clock_in;
		end
		// released line shows no stale bit
		serial_data_in = ~serial_data_in;
	endtask
endmodule
`default_nettype wire

// [tb_spi_slave_receive_channel.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin @(negedge mclk); n_compared++; if ((g) !== (e)) begin bad_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
// ********
// bench top
// ********
module tb_spi_slave_receive_channel;
	import spi_chan_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic slave_serial_clock_in, serial_data_in, serial_data_out, rx_valid, channel_transfer_irq;
	logic channel_start_trigger = 1'b0, channel_stop_trigger = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
	logic overrun_clear = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] serial_data_reg, got, t;
	cfg_t channel_comm_config = '0;
	status_t status;
	int bad_count, n_compared, irq_cnt, cyc, ticks;
	logic [7:0] q[$];
	spi_slave_receive_channel i_spi_slave_receive_channel (.*);
	spi_master_model i_spi_master_model (.*);
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// irq pulse count and hang guard
	always @(posedge mclk) begin
		ticks++;
		if (channel_transfer_irq === 1'b1) irq_cnt++;
		if (ticks > 20000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge mclk);
	endtask
	// one-cycle pulse: start, stop, tx_write, rx_read, overrun_clear
	task automatic strobe(int w);
		tick();
		{channel_start_trigger, channel_stop_trigger, tx_write, rx_read, overrun_clear} <= 5'h10 >> w;
		tick();
		{channel_start_trigger, channel_stop_trigger, tx_write, rx_read, overrun_clear} <= 5'h00;
	endtask
	task automatic arm(cfg_t c);
		i_spi_master_model.park(c.clock_polarity_select);
		tick();
		channel_comm_config <= c;
		strobe(0);
		tick(2);
		`CHK("armed", 1'b1, status.armed)
	endtask
	task automatic halt();
		strobe(1);
		tick(2);
		`CHK("disarmed", 1'b0, status.armed)
	endtask
	// written once armed, since unarmed clears the full flag, and before the master's clock
	task automatic load();
		t = 8'($urandom);
		tick();
		tx_data <= t;
		strobe(2);
		tick(2);
		`CHK("tx_full", 1'b1, status.tx_buffer_full)
	endtask
	// whole frames enter the reference queue, short ones are discarded
	task automatic send(cfg_t c, logic [7:0] d, int nb);
		i_spi_master_model.xfer(c, d, nb, got);
		if (nb >= (c.len7 ? 7 : 8)) q.push_back(c.len7 ? {1'b0, d[6:0]} : d);
		tick(8);
	endtask
	task automatic pull();
		logic [7:0] e;
		e = q.pop_front();
		cyc = 0;
		while (rx_valid !== 1'b1 && cyc < 40) begin
			@(negedge mclk);
			cyc++;
		end
		`CHK("rx_data", e, serial_data_reg)
		strobe(3);
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence; each test except the unarmed one re-arms from scratch instead of resuming
	initial begin
		cfg_t c;
		cyc = $urandom(32'h0C18670C);
		repeat (4) tick();
		resetn <= 1'b1;
		for (int m = 0; m < 16; m++) begin
			c = cfg_t'({2'b00, m[3:0]});
			arm(c);
			irq_cnt = 0;
			send(c, 8'($urandom), 8);
			pull();
			`CHK("end_irq", 1, irq_cnt)
			halt();
		end
		$display("modes test done");
		for (int cm = 0; cm < 2; cm++) begin
			c = cfg_t'({1'b1, cm[0], 4'h0});
			arm(c);
			load();
			irq_cnt = 0;
			send(c, 8'($urandom), 4);
			`CHK("take_irq", cm, irq_cnt)
			`CHK("tx_taken", 1'b0, status.tx_buffer_full)
			halt();
			`CHK("partial", 1'b0, rx_valid)
		end
		// single-transfer duplex over polarity, bit order and frame length
		for (int k = 0; k < 8; k++) begin
			c = cfg_t'({3'b100, k[2:0]});
			arm(c);
			load();
			irq_cnt = 0;
			send(c, 8'($urandom), 8);
			`CHK("tx_bits", (c.len7 ? {1'b0, t[6:0]} : t), got)
			pull();
			`CHK("frame_irq", 1, irq_cnt)
			halt();
		end
		$display("duplex test done");
		c = '0;
		arm(c);
		repeat (18) send(c, 8'($urandom), 8);
		void'(q.pop_back());
		`CHK("overrun", 1'b1, status.overrun_flag)
		repeat (17) pull();
		`CHK("drained", 1'b0, rx_valid)
		`CHK("sticky", 1'b1, status.overrun_flag)
		strobe(4);
		tick(2);
		`CHK("cleared", 1'b0, status.overrun_flag)
		halt();
		$display("overrun test done");
		irq_cnt = 0;
		i_spi_master_model.xfer(c, 8'hA5, 8, got);
		tick(8);
		`CHK("idle_irq", 0, irq_cnt)
		`CHK("idle_rx", 1'b0, rx_valid)
		$display("unarmed test done");
		finish_test();
	end
endmodule
`default_nettype wire
